// file: core/ais_defs.vh
// Register addresses, field positions, reset values and select codes.
`ifndef AIS_DEFS_VH
`define AIS_DEFS_VH
`define AIS_PAGE_MAIN        4'h0
`define AIS_PAGE_CAL         4'hf
`define AIS_ADDR_INPUT_SEL   8'hbb
`define AIS_ADDR_OFFSET_LOW  8'h85
`define AIS_ADDR_OFFSET_HIGH 8'h86
`define AIS_ADDR_REF_CTRL    8'hd1
`define AIS_INPUT_SEL_RESET  5'h1f
`define AIS_REF_CTRL_RESET   8'h18
`define AIS_REF_CTRL_MASK    8'h3d
`define AIS_BIT_REF_OUT_EN   0
`define AIS_BIT_SENSOR_EN    2
`define AIS_BIT_REFSEL_LO    3
`define AIS_BIT_REFSEL_HI    4
`define AIS_BIT_GROUND_SEL   5
`define AIS_CODE_PORT2_BASE  5'h10
`define AIS_CODE_PORT2_LAST  5'h16
`define AIS_CODE_TEMP        5'h1b
`define AIS_CODE_BATTERY     5'h1c
`define AIS_CODE_DIGITAL     5'h1d
`define AIS_CODE_SUPPLY      5'h1e
`define AIS_CODE_GROUND      5'h1f
`define AIS_REF_EXT_PIN      2'h0
`define AIS_REF_SUPPLY       2'h1
`define AIS_REF_DIGITAL      2'h2
`define AIS_REF_HIGH_SPEED   2'h3
`endif

// file: core/ais_source_decode.v
// Decoder from the positive-input code to one-hot analog switch enables.
`timescale 1ns/10ps
`default_nettype none
`include "ais_defs.vh"
module ais_source_decode (
  input  wire [4:0]  code,
  input  wire        port2_present,
  output reg  [22:0] pin_switch,
  output reg         temp_switch,
  output reg         battery_switch,
  output reg         digital_switch,
  output reg         supply_switch,
  output reg         ground_switch,
  output reg         reserved_code
);
  always @* begin
    pin_switch     = 23'h000000;
    temp_switch    = 1'b0;
    battery_switch = 1'b0;
    digital_switch = 1'b0;
    supply_switch  = 1'b0;
    ground_switch  = 1'b0;
    reserved_code  = 1'b0;
    if (code < `AIS_CODE_PORT2_BASE) begin
      pin_switch[code[3:0]] = 1'b1;
    end else if (code <= `AIS_CODE_PORT2_LAST) begin
      // Absent port 2 pins open every switch rather than float a bond pad.
      if (port2_present) begin
        pin_switch[code] = 1'b1;
      end
    end else if (code == `AIS_CODE_TEMP) begin
      temp_switch = 1'b1;
    end else if (code == `AIS_CODE_BATTERY) begin
      battery_switch = 1'b1;
    end else if (code == `AIS_CODE_DIGITAL) begin
      digital_switch = 1'b1;
    end else if (code == `AIS_CODE_SUPPLY) begin
      supply_switch = 1'b1;
    end else if (code == `AIS_CODE_GROUND) begin
      ground_switch = 1'b1;
    end else begin
      // Reserved codes leave every switch open; software must avoid them.
      reserved_code = 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: core/ais_input_ref_select.v
// Input and reference selection registers on the special-function bus.
// Function
// - Five-bit read/write input code at 0xBB, reset to all ones (ground).
// - Input register bits 7:5 read zero; writes there do nothing.
// - Codes from 10000 select port 2 pins 0-6 on larger packages.
// - Top codes pick sensor, battery, digital supply, main rail, ground.
// - Page 0xF address 0x86 reads offset bits 9:2, factory value.
// - Page 0xF address 0x85 reads offset bits 1:0 on top, rest zero.
// - Offset is raw result of a production measurement near 25 C.
// - Reference selector of four sources and a two-way ground selector.
// - Reference code 00 pin, 01 rail, 10 digital, 11 high-speed.
// - Ground select 0 chip ground, 1 analog ground pin.
// - Bit 2 of reference control enables the temperature sensor.
`timescale 1ns/10ps
`default_nettype none
`include "ais_defs.vh"
module ais_input_ref_select (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [3:0]  sfr_page,
  input  wire [7:0]  sfr_addr,
  input  wire        sfr_wr,
  input  wire        sfr_rd,
  input  wire [7:0]  sfr_wdata,
  output reg  [7:0]  sfr_rdata,
  output wire        sfr_hit,
  input  wire [9:0]  factory_temp_offset,
  input  wire        port2_present,
  output wire [22:0] pin_switch,
  output wire        temp_switch,
  output wire        battery_switch,
  output wire        digital_switch,
  output wire        supply_switch,
  output wire        ground_switch,
  output wire        reserved_code,
  output wire [1:0]  reference_source_select,
  output wire        ground_source_select,
  output wire        sensor_enable_bit,
  output wire        ref_out_enable,
  output wire        conv_ground_chip
);
  reg  [4:0] positive_input_code_r;
  reg  [7:0] reference_control_r;
  reg  [9:0] offset_r;
  wire       sel_input;
  wire       sel_ref;
  wire       sel_off_lo;
  wire       sel_off_hi;
  reg  [7:0] rdata_nxt;

  assign sel_input  = (sfr_page == `AIS_PAGE_MAIN) &&
                      (sfr_addr == `AIS_ADDR_INPUT_SEL);
  assign sel_ref    = (sfr_page == `AIS_PAGE_MAIN) &&
                      (sfr_addr == `AIS_ADDR_REF_CTRL);
  assign sel_off_lo = (sfr_page == `AIS_PAGE_CAL) &&
                      (sfr_addr == `AIS_ADDR_OFFSET_LOW);
  assign sel_off_hi = (sfr_page == `AIS_PAGE_CAL) &&
                      (sfr_addr == `AIS_ADDR_OFFSET_HIGH);
  assign sfr_hit = sel_input | sel_ref | sel_off_lo | sel_off_hi;

  always @(posedge clk) begin
    if (!rst_n) begin
      positive_input_code_r <= `AIS_INPUT_SEL_RESET;
      reference_control_r   <= `AIS_REF_CTRL_RESET;
    end else if (sfr_wr) begin
      if (sel_input) begin
        positive_input_code_r <= sfr_wdata[4:0];
      end
      if (sel_ref) begin
        reference_control_r <= sfr_wdata & `AIS_REF_CTRL_MASK;
      end
    end
  end

  // The factory value is fused; it is resampled every cycle after reset release and
  // never written from the bus, so writes to both offset bytes are dropped.
  always @(posedge clk) begin
    if (!rst_n) begin
      offset_r <= 10'h000;
    end else begin
      offset_r <= factory_temp_offset;
    end
  end

  always @* begin
    rdata_nxt = 8'h00;
    if (sel_input) begin
      rdata_nxt = {3'h0, positive_input_code_r};
    end else if (sel_ref) begin
      rdata_nxt = reference_control_r;
    end else if (sel_off_hi) begin
      rdata_nxt = offset_r[9:2];
    end else if (sel_off_lo) begin
      rdata_nxt = {offset_r[1:0], 6'h00};
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata <= rdata_nxt;
    end
  end

  assign reference_source_select =
    reference_control_r[`AIS_BIT_REFSEL_HI:`AIS_BIT_REFSEL_LO];
  assign ground_source_select =
    reference_control_r[`AIS_BIT_GROUND_SEL];
  assign sensor_enable_bit =
    reference_control_r[`AIS_BIT_SENSOR_EN];
  assign ref_out_enable = reference_control_r[`AIS_BIT_REF_OUT_EN];

  // Sensor sampling and the high-speed reference force chip ground.
  assign conv_ground_chip = !ground_source_select || temp_switch ||
    (reference_source_select == `AIS_REF_HIGH_SPEED);

  ais_source_decode u_decode (
    .code           (positive_input_code_r),
    .port2_present  (port2_present),
    .pin_switch     (pin_switch),
    .temp_switch    (temp_switch),
    .battery_switch (battery_switch),
    .digital_switch (digital_switch),
    .supply_switch  (supply_switch),
    .ground_switch  (ground_switch),
    .reserved_code  (reserved_code)
  );
endmodule
`default_nettype wire

// file: tb/ais_analog_src.sv
// Analog side model: the fused sensor offset held as a static level.
`timescale 1ns/10ps
`default_nettype none
module ais_analog_src (
  input  wire logic [9:0] fuse_value,
  output wire logic [9:0] factory_temp_offset);
  assign factory_temp_offset = fuse_value;
endmodule
`default_nettype wire

// file: tb/ais_checker_properties.sv
// Checker for the input selector registers and decoded switches.
`timescale 1ns/10ps
`default_nettype none
module ais_checker (
  input wire logic        clk, rst_n, sfr_wr, sfr_rd, port2_present,
  input wire logic        temp_switch, ground_switch,
  input wire logic [3:0]  sfr_page,
  input wire logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata,
  input wire logic [9:0]  factory_temp_offset,
  input wire logic [22:0] pin_switch);
  logic [4:0] code_r;
  wire logic [11:0] loc = {sfr_page, sfr_addr};
  wire logic [22:0] hot = 23'h1 << code_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk)
    if (!rst_n) code_r <= 5'h1f;
    else if (sfr_wr && loc == 12'h0bb) code_r <= sfr_wdata[4:0];
  a_gnd_code: assert property (ground_switch == (code_r == 5'h1f))
    else $error("ground");
  a_temp_code: assert property (temp_switch == (code_r == 5'h1b))
    else $error("sensor");
  a_gnd_only: assert property (ground_switch |-> pin_switch == 23'h0)
    else $error("pin");
  a_port_low: assert property (code_r < 5'h10 |-> pin_switch == hot)
    else $error("port");
  a_port_two: assert property (code_r inside {[5'h10:5'h16]} |->
    pin_switch == (port2_present ? hot : 23'h0)) else $error("port2");
  a_read_sel: assert property (sfr_rd && loc == 12'h0bb |=>
    sfr_rdata == {3'h0, $past(code_r)}) else $error("read");
  a_off_high: assert property (sfr_rd && loc == 12'hf86 |=>
    sfr_rdata == $past(factory_temp_offset) >> 2) else $error("high");
  a_off_low: assert property (sfr_rd && loc == 12'hf85 |=>
    sfr_rdata == 8'($past(factory_temp_offset) << 6)) else $error("low");
  cover property (sfr_wr && loc == 12'h0bb && sfr_wdata[4:0] == 5'h1b);
  cover property (sfr_rd && loc == 12'hf86);
  cover property (port2_present && pin_switch[22]);
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the input and reference selection registers.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk = 1'h0, rst_n = 1'h0, sfr_wr = 1'h0, sfr_rd = 1'h0, sfr_hit;
  logic port2_present = 1'h0, temp_switch, battery_switch, digital_switch;
  logic supply_switch, ground_switch, reserved_code, ground_source_select;
  logic sensor_enable_bit, ref_out_enable, conv_ground_chip;
  logic [1:0] reference_source_select;
  logic [3:0] sfr_page = 4'h0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, r;
  logic [9:0] fuse = 10'h000, factory_temp_offset;
  logic [22:0] pin_switch;
  int n_fail = 0, n_compared = 0, q;
  ais_analog_src ais_analog_src_i (.fuse_value(fuse), .factory_temp_offset);
  ais_input_ref_select ais_input_ref_select_i (.*);
  task automatic chk(input logic [31:0] got, exp);
    n_compared++;
    n_fail += int'(got !== exp);
    if (got !== exp) $display("unexpected %0t %h %h", $time, got, exp);
  endtask
  // Strobes last one cycle; a read answer has landed when this returns.
  task automatic io(input logic [11:0] loc, logic [7:0] d, logic w);
    @(negedge clk);
    {sfr_page, sfr_addr, sfr_wdata, sfr_wr, sfr_rd} = {loc, d, w, !w};
    @(negedge clk);
    {sfr_wr, sfr_rd} = 2'h0;
    if (!w) chk(sfr_rdata, d);
  endtask
  function automatic logic [5:0] exp_src(input logic [4:0] c);
    exp_src = {c == 5'h1b, c == 5'h1c, c == 5'h1d, c == 5'h1e,
               c == 5'h1f, c > 5'h16 && c < 5'h1b};
  endfunction
  task automatic close_out;
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial forever #5 clk = ~clk;
  initial begin
    #20000 n_fail++;
    close_out;
  end
  initial begin
    void'($urandom(32'h18b47849));
    repeat (5) @(negedge clk);
    rst_n = 1'h1;
    io(12'h0bb, 8'h1f, 1'h0);
    io(12'hfbb, 8'h00, 1'h0);
    chk(sfr_hit, 1'h0);
    io(12'h0d1, 8'h18, 1'h0);
    for (int i = 0; i < 64; i++) begin
      port2_present = i[5];
      io(12'h0bb, {3'($urandom), i[4:0]}, 1'h1);
      q = i % 32 < 16 || i inside {[48:54]} ? 1 << i % 32 : 0;
      chk(pin_switch, q);
      chk({temp_switch, battery_switch, digital_switch, supply_switch,
           ground_switch, reserved_code}, exp_src(i[4:0]));
      chk(sfr_hit, 1'h1);
      io(12'h0bb, {3'h0, i[4:0]}, 1'h0);
    end
    for (int i = 0; i < 8; i++) begin
      r = (8'($urandom) & 8'hc7) | 8'(i << 3);
      io(12'h0d1, r, 1'h1);
      chk(reference_source_select, r[4:3]);
      chk({ground_source_select, sensor_enable_bit}, {r[5], r[2]});
      chk({ref_out_enable, conv_ground_chip},
          {r[0], !r[5] || r[4:3] == 2'h3});
      io(12'h0d1, r & 8'h3d, 1'h0);
    end
    repeat (3) begin
      fuse = 10'($urandom);
      io(12'hf85, 8'hff, 1'h1);
      io(12'hf86, fuse[9:2], 1'h0);
      io(12'hf85, {fuse[1:0], 6'h00}, 1'h0);
    end
    close_out;
  end
endmodule
bind ais_input_ref_select ais_checker ais_checker_i (.*);
`default_nettype wire
